// ### bench/csc_clock_control_tb_top.sv
// Self-checking bench for the clock source and start-up control block.
// Assumes the oscillator model periods of 8 and 12 mclk cycles.
`timescale 1ns/1ps
module csc_clock_control_tb_top;
   import csc_pkg::*;
   localparam int TL = 32;
   localparam int S16 = 64;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, coreRstN, sysTick, wdogOsc, sysOsc;
   logic fuseValid = 1'b0;
   logic [3:0] clockSourceSelect = 4'hF;
   logic [1:0] startupTimeSelect = 2'h3;
   logic divideByEightFuse = 1'b1;
   logic extIntIn = 1'b0;
   logic serialStartIn = 1'b0;
   logic twoWireAddrIn = 1'b0;
   logic wdRun = 1'b1;
   logic [NUM_DOM-1:0] clkEn;
   int n_mismatch = 0;
   int compares = 0;

   always #2 mclk = ~mclk;

   csc_osc_model i_osc (.wdRun(wdRun), .wdogOsc(wdogOsc), .sysOsc(sysOsc));

   csc_clock_control
   #(
      .TOUT_LONG_CYC(16'h0020),
      .START_16K_CYC(16'h0040),
      .START_LF_CYC(16'h0080)
   )
   i_dut
   (
      .mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fuseValid(fuseValid), .clockSourceSelect(clockSourceSelect),
      .startupTimeSelect(startupTimeSelect), .divideByEightFuse(divideByEightFuse),
      .wdogOsc(wdogOsc), .sysOsc(sysOsc), .extIntIn(extIntIn),
      .serialStartIn(serialStartIn), .twoWireAddrIn(twoWireAddrIn),
      .coreRstN(coreRstN), .sysTick(sysTick), .clkEn(clkEn)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_rng(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic give_verdict;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 100)
      begin
         n++;
         @(posedge mclk);
      end
      if (n >= 100)
         n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [2:0] src_of(input logic [3:0] c);
      if (c[3])
         return 3'h0;
      if (c[2:1] == 2'b11)
         return 3'h1;
      if (c[2:1] == 2'b10)
         return 3'h2;
      return c[1] ? (c[0] ? 3'h3 : 3'h4) : (c[0] ? 3'h6 : 3'h5);
   endfunction

   task automatic apply_reset(input logic fv, input logic [3:0] cks, input logic [1:0] stSel,
      input logic d8);
      // With fuses invalid the pins carry the opposite of the defaults
      fuseValid <= fv;
      clockSourceSelect <= fv ? cks : ~cks;
      startupTimeSelect <= fv ? stSel : ~stSel;
      divideByEightFuse <= fv ? d8 : ~d8;
      nrst <= 1'b0;
      repeat (16) @(posedge mclk);
      check({31'h0, coreRstN}, 32'h0);
      check({27'h0, clkEn}, 32'h0);
      nrst <= 1'b1;
   endtask

   // Boot time is time-out on 8-cycle watchdog plus start-up on 12-cycle source
   task automatic boot(input logic fv, input logic [3:0] cks, input logic [1:0] stSel,
      input logic d8, input int t, input int s);
      int n;
      int e;
      int tk;
      logic [31:0] rd;
      logic err;
      wdRun <= (t != 0);
      apply_reset(fv, cks, stSel, d8);
      n = 0;
      while (coreRstN !== 1'b1 && n < 20000)
      begin
         n++;
         @(posedge mclk);
      end
      e = 3 + 8 * t + 12 * s;
      check_rng(n, e - 24, e + 48);
      apb(1'b0, STAT_OFS, 32'h0, rd, err);
      check(rd, {17'h0, 1'b1, 1'b0, 3'h3, src_of(cks), d8, stSel, cks});
      tk = 0;
      repeat (64)
      begin
         @(posedge mclk);
         if (sysTick === 1'b1)
            tk++;
      end
      check_rng(tk, d8 ? 64 : 8, d8 ? 64 : 8);
      check({27'h0, clkEn}, 32'h1F);
   endtask

   task automatic decode_all;
      logic [31:0] rd;
      logic err;
      for (int i = 0; i < 16; i++)
      begin
         apply_reset(1'b1, i[3:0], 2'b10, 1'b1);
         repeat (8) @(posedge mclk);
         apb(1'b0, STAT_OFS, 32'h0, rd, err);
         check(rd & 32'h3FF, {22'h0, src_of(i[3:0]), 1'b1, 2'b10, i[3:0]});
      end
   endtask

   task automatic sleep_wake(input logic [2:0] m, input logic [4:0] en, input int w,
      input int s);
      int n;
      logic [31:0] rd;
      logic err;
      apb(1'b1, CTRL_OFS, {27'h0, 1'b1, 1'b1, m}, rd, err);
      repeat (20) @(posedge mclk);
      check({27'h0, clkEn}, {27'h0, en});
      if (w == 0)
         extIntIn <= 1'b1;
      else if (w == 1)
         serialStartIn <= 1'b1;
      else
         twoWireAddrIn <= 1'b1;
      n = 0;
      while (clkEn[DOM_CPU] !== 1'b1 && n < 20000)
      begin
         n++;
         @(posedge mclk);
      end
      check_rng(n, 12 * s - 24, 12 * s + 60);
      check({31'h0, coreRstN}, 32'h1);
      apb(1'b0, STAT_OFS, 32'h0, rd, err);
      check({31'h0, rd[STAT_WAKE_BIT]}, 32'h1);
      apb(1'b1, STAT_OFS, 32'h0000_2000, rd, err);
      apb(1'b0, STAT_OFS, 32'h0, rd, err);
      check({31'h0, rd[STAT_WAKE_BIT]}, 32'h0);
      extIntIn <= 1'b0;
      serialStartIn <= 1'b0;
      twoWireAddrIn <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic run_checks;
      logic [31:0] rd;
      logic err;
      apb(1'b1, HALT_OFS, 32'h1, rd, err);
      repeat (4) @(posedge mclk);
      check({27'h0, clkEn}, 32'h1A);
      apb(1'b1, HALT_OFS, 32'h0, rd, err);
      apb(1'b0, 12'h00C, 32'h0, rd, err);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h1);
   endtask

   initial
   begin
      // Factory defaults when fuses are not valid
      boot(1'b0, 4'h2, 2'b10, 1'b0, TL, 6);
      decode_all();
      // Zero time-out only where a brown-out detector is assumed
      boot(1'b1, 4'h0, 2'b00, 1'b1, 0, 6);
      boot(1'b1, 4'h3, 2'b01, 1'b0, 512, 6);
      boot(1'b1, 4'hF, 2'b01, 1'b1, 0, S16);
      boot(1'b1, 4'h9, 2'b11, 1'b0, TL, S16);
      boot(1'b1, 4'h6, 2'b00, 1'b1, 512, 258);
      run_checks();
      sleep_wake(3'h0, 5'h1A, 0, 0);
      sleep_wake(3'h1, 5'h18, 1, 0);
      sleep_wake(3'h3, 5'h08, 2, 258);
      sleep_wake(3'h2, 5'h00, 0, 258);
      sleep_wake(3'h4, 5'h00, 2, 0);
      give_verdict();
   end

   initial
   begin
      repeat (90000) @(posedge mclk);
      n_mismatch++;
      give_verdict();
   end
endmodule

// ### bench/csc_osc_model.sv
// Oscillator pins seen by the clock control block: watchdog and selected source.
// Assumes a 4 ns mclk; both oscillators stay well below mclk/4.
`timescale 1ns/1ps
module csc_osc_model
#(
   parameter int WD_HALF = 16,
   parameter int SYS_HALF = 24
)
(
   // Control
   input wire logic wdRun,
   // Oscillator pins
   output logic wdogOsc,
   output logic sysOsc
);
   initial wdogOsc = 1'b0;
   initial sysOsc = 1'b0;
   // Stopped watchdog parks low, so a zero time-out must not need it
   always #(WD_HALF) wdogOsc = wdRun ? ~wdogOsc : 1'b0;
   // Selected source free-runs, as a real oscillator does
   always #(SYS_HALF) sysOsc = ~sysOsc;
endmodule

// ### verilog/csc_clock_control.sv
// Clock source select, start-up sequencing and domain gating, APB slave.
// Assumes fuses are static pins and both oscillators are slow pins.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module csc_clock_control
#(
   parameter logic [15:0] TOUT_LONG_CYC = csc_pkg::TOUT_LONG,
   parameter logic [15:0] START_16K_CYC = csc_pkg::START_16K,
   parameter logic [15:0] START_LF_CYC = csc_pkg::START_LF
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration fuses
   input wire logic fuseValid,
   input wire logic [3:0] clockSourceSelect,
   input wire logic [1:0] startupTimeSelect,
   input wire logic divideByEightFuse,
   // Oscillator pins
   input wire logic wdogOsc,
   input wire logic sysOsc,
   // Wake inputs
   input wire logic extIntIn,
   input wire logic serialStartIn,
   input wire logic twoWireAddrIn,
   // Outputs to the core
   output logic coreRstN,
   output logic sysTick,
   output logic [csc_pkg::NUM_DOM-1:0] clkEn
);
   import csc_pkg::*;

   typedef struct packed {
      csc_state_type state;
      logic [1:0] holdCnt;
      logic [6:0] fuseS1;
      logic [6:0] fuseS2;
      logic validS1;
      logic validS2;
      logic [3:0] srcSel;
      logic [1:0] stSel;
      logic div8;
      logic fuseOk;
      csc_sleep_type mode;
      logic sleepEn;
      logic [4:0] haltMask;
      logic wakeFlag;
      logic [2:0] wakeS1;
      logic [2:0] wakeS2;
      logic [2:0] div;
      logic tick;
      logic startT;
      logic startO;
      logic [15:0] loadT;
      logic [15:0] loadO;
      logic rstN;
      logic [31:0] rdata;
      logic slverr;
   } csc_top_state_type;

   csc_top_state_type r;
   csc_top_state_type n;
   logic [6:0] fuseSel;
   logic apbWr;
   logic apbSetup;
   logic sleepGo;
   logic wakeEvt;
   logic [NUM_DOM-1:0] domReq;
   csc_src_type src;
   csc_count_if toutIf();
   csc_count_if oscIf();

   function automatic csc_src_type srcOf(input logic [3:0] c);
      if (c[3])
         srcOf = SRC_LP_XTAL;
      else if (c[3:1] == 3'h3)
         srcOf = SRC_FS_XTAL;
      else if (c[3:1] == 3'h2)
         srcOf = SRC_LF_XTAL;
      else if (c == 4'h3)
         srcOf = SRC_RC128;
      else if (c == 4'h2)
         srcOf = SRC_RC_CAL;
      else if (c == 4'h0)
         srcOf = SRC_EXT;
      else
         srcOf = SRC_RSVD;
   endfunction

   function automatic logic isXtal(input logic [3:0] c);
      isXtal = (srcOf(c) == SRC_LP_XTAL) || (srcOf(c) == SRC_FS_XTAL);
   endfunction

   function automatic logic [15:0] toutOf(input logic [3:0] c, input logic [1:0] u);
      logic [2:0] k;
      k = {c[0], u};
      if (isXtal(c))
      begin
         case (k)
            3'h0, 3'h3, 3'h6: toutOf = TOUT_SHORT;
            3'h1, 3'h4, 3'h7: toutOf = TOUT_LONG_CYC;
            default: toutOf = TOUT_NONE;
         endcase
      end
      else
      begin
         case (u)
            2'h0: toutOf = TOUT_NONE;
            2'h1: toutOf = TOUT_SHORT;
            default: toutOf = TOUT_LONG_CYC;
         endcase
      end
   endfunction

   function automatic logic [15:0] startOf(input logic [3:0] c, input logic [1:0] u);
      logic [2:0] k;
      k = {c[0], u};
      if (isXtal(c))
      begin
         case (k)
            3'h0, 3'h1: startOf = START_258;
            3'h2, 3'h3, 3'h4: startOf = START_1K;
            default: startOf = START_16K_CYC;
         endcase
      end
      else if (srcOf(c) == SRC_EXT)
         startOf = START_EXT;
      else if (srcOf(c) == SRC_LF_XTAL || srcOf(c) == SRC_RSVD)
         startOf = START_LF_CYC;
      else
         startOf = START_RC;
   endfunction

   // Flash always mirrors CPU; converter and timer may run alone
   function automatic logic [4:0] reqOf(input csc_state_type st,
      input csc_sleep_type m, input logic [4:0] h);
      logic [4:0] q;
      q = 5'h00;
      case (st)
         ST_RUN: q = ~h;
         ST_SLEEP:
         begin
            q[DOM_ASY] = (m != SLP_PDOWN) && (m != SLP_STBY);
            q[DOM_ADC] = (m == SLP_IDLE) || (m == SLP_ADC);
            q[DOM_IO] = (m == SLP_IDLE);
         end
         default: q[DOM_ASY] = 1'b1;
      endcase
      q[DOM_FLASH] = q[DOM_CPU];
      return q;
   endfunction

   assign fuseSel = r.validS2 ? r.fuseS2 : {SRC_SEL_DFLT, START_SEL_DFLT, DIV8_DFLT};
   assign apbWr = psel & penable & pwrite;
   assign apbSetup = psel & ~penable;
   assign sleepGo = apbWr && (paddr == CTRL_OFS) && pwdata[CTRL_SLREQ_BIT]
      && pwdata[CTRL_SLEN_BIT];
   // Plain mclk logic, independent of the I/O domain enable
   assign wakeEvt = (|r.wakeS2) && (r.state == ST_SLEEP);
   assign src = srcOf(r.srcSel);
   assign domReq = reqOf(r.state, r.mode, r.haltMask);

   assign toutIf.start = r.startT;
   assign toutIf.load = r.loadT;
   assign oscIf.start = r.startO;
   assign oscIf.load = r.loadO;

   always_comb
   begin
      n = r;
      n.startT = 1'b0;
      n.startO = 1'b0;
      n.fuseS1 = {clockSourceSelect, startupTimeSelect, divideByEightFuse};
      n.fuseS2 = r.fuseS1;
      n.validS1 = fuseValid;
      n.validS2 = r.validS1;
      n.wakeS1 = {twoWireAddrIn, serialStartIn, extIntIn};
      n.wakeS2 = r.wakeS1;
      if (r.div8 == FUSE_PROG)
      begin
         n.div = r.div + 3'h1;
         n.tick = (r.div == DIV_MAX);
      end
      else
      begin
         n.div = 3'h0;
         n.tick = 1'b1;
      end
      case (r.state)
         ST_HOLD:
         begin
            n.holdCnt = r.holdCnt + 2'h1;
            if (r.holdCnt == SYNC_HOLD)
            begin
               n.srcSel = fuseSel[6:3];
               n.stSel = fuseSel[2:1];
               n.div8 = fuseSel[0];
               n.fuseOk = r.validS2;
               n.startT = 1'b1;
               n.loadT = toutOf(fuseSel[6:3], fuseSel[2:1]);
               n.state = ST_TOUT;
            end
         end
         ST_TOUT:
            if (toutIf.done)
            begin
               n.startO = 1'b1;
               n.loadO = startOf(r.srcSel, r.stSel);
               n.state = ST_START;
            end
         ST_START:
            if (oscIf.done)
            begin
               n.rstN = 1'b1;
               n.state = ST_RUN;
            end
         ST_RUN:
            if (sleepGo)
               n.state = ST_SLEEP;
         ST_SLEEP:
            if (wakeEvt)
            begin
               if (r.mode == SLP_PDOWN || r.mode == SLP_PSAVE)
               begin
                  n.startO = 1'b1;
                  n.loadO = startOf(r.srcSel, r.stSel);
                  n.state = ST_WAKE;
               end
               else
                  n.state = ST_RUN;
            end
         ST_WAKE:
            if (oscIf.done)
               n.state = ST_RUN;
         default: n.state = ST_HOLD;
      endcase
      // Sticky wake flag: a new wake beats a software clear
      n.wakeFlag = r.wakeFlag | wakeEvt;
      if (apbWr && paddr == STAT_OFS && pwdata[STAT_WAKE_BIT] && !wakeEvt)
         n.wakeFlag = 1'b0;
      if (apbWr && paddr == CTRL_OFS)
      begin
         n.mode = csc_sleep_type'(pwdata[CTRL_MODE_LSB +: 3]);
         n.sleepEn = pwdata[CTRL_SLEN_BIT];
      end
      else if (apbWr && paddr == HALT_OFS)
         n.haltMask = pwdata[NUM_DOM-1:0];
      // Read data captured in setup so access completes with no wait
      if (apbSetup)
      begin
         n.rdata = 32'h0000_0000;
         n.slverr = 1'b0;
         if (paddr == CTRL_OFS)
         begin
            n.rdata[CTRL_MODE_LSB +: 3] = r.mode;
            n.rdata[CTRL_SLEN_BIT] = r.sleepEn;
         end
         else if (paddr == HALT_OFS)
            n.rdata[NUM_DOM-1:0] = r.haltMask;
         else if (paddr == STAT_OFS)
         begin
            n.rdata[STAT_SRCSEL_LSB +: 4] = r.srcSel;
            n.rdata[STAT_STSEL_LSB +: 2] = r.stSel;
            n.rdata[STAT_DIV8_BIT] = r.div8;
            n.rdata[STAT_SRC_LSB +: 3] = src;
            n.rdata[STAT_STATE_LSB +: 3] = r.state;
            n.rdata[STAT_WAKE_BIT] = r.wakeFlag;
            n.rdata[STAT_RSTN_BIT] = r.rstN;
         end
         else
            n.slverr = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         r <= '0;
         r.srcSel <= SRC_SEL_DFLT;
         r.stSel <= START_SEL_DFLT;
         r.div8 <= 1'b1;
         r.tick <= 1'b1;
      end
      else
         r <= n;
   end

   csc_edge_counter toutCnt (
      .mclk(mclk),
      .nrst(nrst),
      .oscIn(wdogOsc),
      .cnt(toutIf)
   );

   csc_edge_counter oscCnt (
      .mclk(mclk),
      .nrst(nrst),
      .oscIn(sysOsc),
      .cnt(oscIf)
   );

   genvar d;
   generate
      for (d = 0; d < NUM_DOM; d++)
      begin : gateGen
         csc_clock_gate gate (
            .mclk(mclk),
            .nrst(nrst),
            .tick(r.tick),
            .req(domReq[d]),
            .en(clkEn[d])
         );
      end
   endgenerate

   assign prdata = r.rdata;
   assign pready = 1'b1;
   assign pslverr = r.slverr;
   assign coreRstN = r.rstN;
   assign sysTick = r.tick;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence toutDone_s;
      r.state == ST_TOUT && toutIf.done;
   endsequence
   sequence oscLoad_s;
      r.startO && r.state == ST_START;
   endsequence

   counterHoldsReset_a: assert property (toutIf.busy || (oscIf.busy && r.state == ST_START)
      |-> !coreRstN)
      else $error("core reset released while a counter runs");
   toutThenStart_a: assert property (toutDone_s |=> oscLoad_s ##1 oscIf.busy || oscIf.done)
      else $error("start-up count did not follow time-out");
   wakeNoTout_a: assert property (r.startT |-> $past(r.state) == ST_HOLD && !coreRstN)
      else $error("time-out started outside reset");
   toutLength_a: assert property (r.startT |-> r.loadT == TOUT_NONE
      || r.loadT == TOUT_SHORT || r.loadT == TOUT_LONG_CYC)
      else $error("illegal time-out length");
   extStart_a: assert property (r.startO && src == SRC_EXT |-> r.loadO == START_EXT)
      else $error("external clock start-up count wrong");
   srcDecode_a: assert property (r.srcSel == 4'h2 |-> src == SRC_RC_CAL
      && (r.srcSel[3] || src != SRC_LP_XTAL))
      else $error("clock source decode wrong");
   defaultFuse_a: assert property (r.state != ST_HOLD && !r.fuseOk |-> r.srcSel == SRC_SEL_DFLT
      && r.stSel == START_SEL_DFLT && r.div8 == DIV8_DFLT)
      else $error("default fuse set not applied");
   divEight_a: assert property (r.tick && r.div8 == FUSE_PROG && $past(r.div8) == FUSE_PROG
      |=> !r.tick [*7] ##1 r.tick)
      else $error("divided tick spacing not eight");
   flashCpu_a: assert property (clkEn[DOM_FLASH] == clkEn[DOM_CPU])
      else $error("flash clock not tied to CPU clock");
   gateOnTick_a: assert property ($changed(clkEn) |-> $past(r.tick))
      else $error("domain enable moved off a tick");
   cpuHaltSleep_a: assert property ($rose(r.state == ST_SLEEP) |-> ##[1:9] !clkEn[DOM_CPU])
      else $error("CPU clock still running in sleep");
   wakeSeen_a: assert property (wakeEvt |=> r.state != ST_SLEEP && r.wakeFlag)
      else $error("wake missed while asleep");
endmodule

// ### verilog/csc_clock_gate.sv
// Glitch-free enable for one clock domain.
// Assumes tick is a single-cycle prescaler strobe on mclk.
`timescale 1ns/1ps
module csc_clock_gate
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Control
   input wire logic tick,
   input wire logic req,
   // Domain enable
   output logic en
);
   typedef struct packed {
      logic en;
   } csc_gate_state_type;

   csc_gate_state_type r;
   csc_gate_state_type n;

   assign en = r.en;

   // Only moves on a prescaled period boundary, so no short pulse escapes
   always_comb
   begin
      n = r;
      if (tick)
         n.en = req;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         r <= '0;
      else
         r <= n;
   end
endmodule

// ### verilog/csc_count_if.sv
// Start/done handshake between the sequencer and one cycle counter.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface csc_count_if;
   logic start;
   logic [15:0] load;
   logic busy;
   logic done;
   modport counter (input start, input load, output busy, output done);
   modport ctrl (output start, output load, input busy, input done);
endinterface

// ### verilog/csc_edge_counter.sv
// Counts rising edges of an oscillator pin down from a loaded value.
// Assumes the oscillator is well below mclk/2; pin is synchronised here.
`timescale 1ns/1ps
module csc_edge_counter
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Oscillator pin
   input wire logic oscIn,
   // Sequencer side
   csc_count_if.counter cnt
);
   import csc_pkg::*;

   typedef struct packed {
      logic [1:0] sync;
      logic prev;
      logic [15:0] cnt;
      logic busy;
      logic done;
   } csc_cnt_state_type;

   csc_cnt_state_type r;
   csc_cnt_state_type n;
   logic oscEdge;

   assign oscEdge = r.sync[1] & ~r.prev;
   assign cnt.busy = r.busy;
   assign cnt.done = r.done;

   always_comb
   begin
      n = r;
      n.sync = {r.sync[0], oscIn};
      n.prev = r.sync[1];
      n.done = 1'b0;
      if (cnt.start)
      begin
         n.cnt = cnt.load;
         n.busy = (cnt.load != 16'h0000);
         n.done = (cnt.load == 16'h0000);
      end
      else if (r.busy && oscEdge)
      begin
         n.cnt = r.cnt - 16'h0001;
         if (r.cnt == 16'h0001)
         begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         r <= '0;
      else
         r <= n;
   end

   lastEdge_done_a: assert property (@(posedge mclk) disable iff (!nrst)
      r.busy && oscEdge && r.cnt == 16'h0001 && !cnt.start |=> r.done && !r.busy)
      else $error("counter did not finish on last edge");
   zeroLoad_done_a: assert property (@(posedge mclk) disable iff (!nrst)
      cnt.start && cnt.load == 16'h0000 |=> r.done ##1 !r.done)
      else $error("zero load did not finish at once");
endmodule

// ### verilog/csc_pkg.sv
// Constants and types for the clock source and start-up control block.
// Assumes a single 250 MHz system clock; oscillators arrive as plain pins.
package csc_pkg;
   // APB register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] HALT_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;
   // CTRL fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SLEN_BIT = 3;
   localparam int CTRL_SLREQ_BIT = 4;
   // STAT fields
   localparam int STAT_SRCSEL_LSB = 0;
   localparam int STAT_STSEL_LSB = 4;
   localparam int STAT_DIV8_BIT = 6;
   localparam int STAT_SRC_LSB = 7;
   localparam int STAT_STATE_LSB = 10;
   localparam int STAT_WAKE_BIT = 13;
   localparam int STAT_RSTN_BIT = 14;
   // Clock domains
   localparam int NUM_DOM = 5;
   localparam int DOM_CPU = 0;
   localparam int DOM_IO = 1;
   localparam int DOM_FLASH = 2;
   localparam int DOM_ASY = 3;
   localparam int DOM_ADC = 4;
   // Cycle counts (watchdog or selected oscillator cycles)
   localparam int CNT_W = 16;
   localparam logic [15:0] TOUT_NONE = 16'h0000;
   localparam logic [15:0] TOUT_SHORT = 16'h0200;
   localparam logic [15:0] TOUT_LONG = 16'h2000;
   localparam logic [15:0] START_258 = 16'h0102;
   localparam logic [15:0] START_1K = 16'h0400;
   localparam logic [15:0] START_16K = 16'h4000;
   localparam logic [15:0] START_LF = 16'h8000;
   localparam logic [15:0] START_EXT = 16'h0006;
   localparam logic [15:0] START_RC = 16'h0006;
   // Fuses: zero means programmed
   localparam logic FUSE_PROG = 1'b0;
   localparam logic [3:0] SRC_SEL_DFLT = 4'h2;
   localparam logic [1:0] START_SEL_DFLT = 2'h2;
   localparam logic DIV8_DFLT = 1'b0;
   localparam logic [2:0] DIV_MAX = 3'h7;
   localparam logic [1:0] SYNC_HOLD = 2'h2;

   typedef enum logic [2:0] {SRC_LP_XTAL, SRC_FS_XTAL, SRC_LF_XTAL, SRC_RC128,
      SRC_RC_CAL, SRC_EXT, SRC_RSVD} csc_src_type;
   typedef enum logic [2:0] {SLP_IDLE, SLP_ADC, SLP_PDOWN, SLP_PSAVE,
      SLP_STBY} csc_sleep_type;
   typedef enum logic [2:0] {ST_HOLD, ST_TOUT, ST_START, ST_RUN, ST_SLEEP,
      ST_WAKE} csc_state_type;
endpackage
